// File: src/lsic_pkg.sv
// Constants shared by the LED status indicator control block
package lsic_pkg;
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned SLOW_FLASH_MS  = 500;
  localparam int unsigned FAST_FLASH_MS  = 125;
  localparam int unsigned STEP_MS        = 150;
  localparam int unsigned SLOW_CYC = CLK_HZ / 1000 * SLOW_FLASH_MS;
  localparam int unsigned FAST_CYC = CLK_HZ / 1000 * FAST_FLASH_MS;
  localparam int unsigned STEP_CYC = CLK_HZ / 1000 * STEP_MS;
  localparam int unsigned NUM_LEVELS   = 5;
  localparam int unsigned BATT_LEDS    = 10;
  localparam int unsigned SPEED_LEDS   = 5;
  localparam int unsigned ACT_LEDS     = 5;
  localparam logic [2:0]  LEVEL_RESET  = 3'h1;
  localparam logic [2:0]  LEVEL_MIN    = 3'h1;
  localparam logic [2:0]  ACT_RESET    = 3'h0;
  localparam logic [1:0]  BATT_FULL    = 2'h0;
  localparam logic [1:0]  BATT_SOON    = 2'h1;
  localparam logic [1:0]  BATT_URGENT  = 2'h2;
  localparam logic [9:0]  BAR_FULL     = 10'h3FF;
  localparam logic [9:0]  BAR_SOON     = 10'h07F;
  localparam logic [9:0]  BAR_URGENT   = 10'h007;
  localparam logic [4:0]  REBOOT_MASK  = 5'h0A;
  localparam logic [3:0]  CODE_LEFT_OPEN   = 4'h2;
  localparam logic [3:0]  CODE_LEFT_SHORT  = 4'h3;
  localparam logic [3:0]  CODE_RIGHT_OPEN  = 4'h4;
  localparam logic [3:0]  CODE_RIGHT_SHORT = 4'h5;
  localparam logic [3:0]  CODE_COMMS       = 4'h7;
  localparam logic [3:0]  CODE_MAX         = 4'hA;
  typedef enum logic [1:0] {
    LSIC_MODE_DRIVE   = 2'b00,
    LSIC_MODE_SEATING = 2'b01,
    LSIC_MODE_ACT     = 2'b10,
    LSIC_MODE_OTHER   = 2'b11
  } lsic_mode_type;
endpackage

// File: src/lsic_led_status.sv
// LED status indicator control: gauges, buttons, modes and trip codes
//
// Overview of operation
// RULE1 - Five max speed levels, 1 slowest, 5 fastest.
// RULE2 - Profile operation offers up to five profiles, count set by config.
// RULE3 - Decrease press lowers speed level or selects lower profile.
// RULE4 - Increase press raises speed level or selects higher profile.
// RULE5 - Option ignores speed/profile buttons while driving; else always act.
// RULE6 - Mode press advances to next enabled and present mode.
// RULE7 - Modes other than drive or seating blank speed and actuator LEDs.
// RULE8 - Actuator mode lights LEDs identifying selected actuator channel.
// RULE9 - Sideways joystick steps channel; forward/back drives selected actuator.
// RULE10 - Battery gauge steady when normal, slow flash when battery low.
// RULE11 - Charging steps gauge up; drive inhibited until charger off and repower.
// RULE12 - Trip prevents motion and flashes battery gauge rapidly.
// RULE13 - Trip code shown as count of flashing battery LEDs, one to ten.
// RULE14 - Codes 1-5: battery, left open, left short, right open, right short.
// RULE15 - Codes 6-10: inhibit, joystick, system, brake, overvoltage.
// RULE16 - Comms fault: seven LEDs plus speed gauge; actuator trip flashes actuators.
// RULE17 - Motor swap option exchanges left and right motor trip codes.
// RULE18 - Reconfiguring ripples speed gauge from centre outward.
// RULE19 - Reboot required flashes speed LEDs two and four.
// RULE20 - Speed mode lights left-justified bar of level length.
// RULE21 - Profile mode lights only LED at selected profile position.
// RULE22 - Locked system ripples speed/profile gauge up and down.
// RULE23 - Battery gauge lights 1-10 full, 1-7 soon, 1-3 urgent.
// RULE24 - Trip display outranks charging, lock, reconfiguration and normal.
`timescale 1ns/1ps
module lsic_led_status #(
  parameter int unsigned SLOW_CYCLES = lsic_pkg::SLOW_CYC,
  parameter int unsigned FAST_CYCLES = lsic_pkg::FAST_CYC,
  parameter int unsigned STEP_CYCLES = lsic_pkg::STEP_CYC
) (
  input  wire logic       core_clk_in,
  input  wire logic       rstn_in,
  input  wire logic       dec_btn_in,
  input  wire logic       inc_btn_in,
  input  wire logic       mode_btn_in,
  input  wire logic       joy_left_in,
  input  wire logic       joy_right_in,
  input  wire logic       joy_fwd_in,
  input  wire logic       joy_back_in,
  input  wire logic       driving_in,
  input  wire logic       profile_cfg_in,
  input  wire logic [2:0] profile_count_in,
  input  wire logic       lock_out_btn_cfg_in,
  input  wire logic [3:0] mode_avail_in,
  input  wire logic       motor_swap_cfg_in,
  input  wire logic [1:0] batt_level_in,
  input  wire logic       batt_low_in,
  input  wire logic       charging_in,
  input  wire logic       trip_in,
  input  wire logic [3:0] trip_code_in,
  input  wire logic       comms_fault_in,
  input  wire logic       act_trip_in,
  input  wire logic       reconfig_in,
  input  wire logic       reboot_req_in,
  input  wire logic       locked_in,
  output logic      [9:0] batt_led_out,
  output logic      [4:0] speed_led_out,
  output logic      [4:0] act_led_out,
  output logic      [1:0] mode_out,
  output logic      [2:0] level_out,
  output logic      [2:0] act_sel_out,
  output logic            act_up_out,
  output logic            act_down_out,
  output logic            drive_inhibit_out
);
  // Slow-rate enables from free-running dividers
  logic [31:0] slow_cnt;
  logic [31:0] fast_cnt;
  logic [31:0] step_cnt;
  logic        slow_ph;
  logic        fast_ph;
  logic        step_en;
  logic [3:0]  anim;
  logic        dec_q;
  logic        inc_q;
  logic        mode_q;
  logic        side_q;
  logic        chg_seen;
  lsic_pkg::lsic_mode_type mode;
  logic [2:0]  level;
  logic [2:0]  act_sel;

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      slow_cnt <= '0;
      fast_cnt <= '0;
      step_cnt <= '0;
      slow_ph  <= 1'b0;
      fast_ph  <= 1'b0;
      step_en  <= 1'b0;
      anim     <= 4'h0;
    end
    else
    begin
      slow_cnt <= (slow_cnt >= SLOW_CYCLES - 1) ? '0 : slow_cnt + 32'h1;
      fast_cnt <= (fast_cnt >= FAST_CYCLES - 1) ? '0 : fast_cnt + 32'h1;
      step_cnt <= (step_cnt >= STEP_CYCLES - 1) ? '0 : step_cnt + 32'h1;
      step_en  <= (step_cnt >= STEP_CYCLES - 1);
      if (slow_cnt >= SLOW_CYCLES - 1)
        slow_ph <= ~slow_ph;
      if (fast_cnt >= FAST_CYCLES - 1)
        fast_ph <= ~fast_ph;
      if (step_en)
        anim <= (anim == 4'h9) ? 4'h0 : anim + 4'h1;
    end
  end

  // Press edges; buttons are taken as already debounced
  wire dec_press  = dec_btn_in & ~dec_q;
  wire inc_press  = inc_btn_in & ~inc_q;
  wire mode_press = mode_btn_in & ~mode_q;
  wire side_now   = joy_left_in | joy_right_in;
  wire btn_ok     = ~(lock_out_btn_cfg_in & driving_in);       // RULE5
  wire [2:0] top  = profile_cfg_in ?
                    ((profile_count_in == 3'h0 || profile_count_in > 3'h5) ?
                     3'h5 : profile_count_in) :                // RULE2
                    3'(lsic_pkg::NUM_LEVELS);                  // RULE1
  wire do_dec     = dec_press & btn_ok & (level > lsic_pkg::LEVEL_MIN);
  wire do_inc     = inc_press & btn_ok & (level < top);
  wire in_act     = (mode == lsic_pkg::LSIC_MODE_SEATING);

  // Next available mode by rotating search over the enable mask
  logic [1:0] next_mode;
  always_comb
  begin
    next_mode = mode;
    for (int i = 3; i >= 1; i--)
      if (mode_avail_in[2'(mode + 2'(i))])
        next_mode = 2'(mode + 2'(i));
  end

  wire [2:0] next_act = joy_right_in ?
                        ((act_sel == 3'h4) ? 3'h0 : act_sel + 3'h1) :
                        ((act_sel == 3'h0) ? 3'h4 : act_sel - 3'h1);

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      dec_q    <= 1'b0;
      inc_q    <= 1'b0;
      mode_q   <= 1'b0;
      side_q   <= 1'b0;
      chg_seen <= 1'b0;
      mode     <= lsic_pkg::LSIC_MODE_DRIVE;
      level    <= lsic_pkg::LEVEL_RESET;
      act_sel  <= lsic_pkg::ACT_RESET;
    end
    else
    begin
      dec_q  <= dec_btn_in;
      inc_q  <= inc_btn_in;
      mode_q <= mode_btn_in;
      side_q <= side_now;
      // Latched until power cycle, which is the only reset here
      if (charging_in)
        chg_seen <= 1'b1;                                      // RULE11
      if (mode_press)
        mode <= lsic_pkg::lsic_mode_type'(next_mode);          // RULE6
      if (do_dec)
        level <= level - 3'h1;                                 // RULE3
      else if (do_inc)
        level <= level + 3'h1;                                 // RULE4
      else if (level > top)
        level <= top;
      if (in_act && side_now && !side_q)
        act_sel <= next_act;                                   // RULE9
    end
  end

  // Trip code mapping with optional left/right swap
  logic [3:0] code;
  always_comb
  begin
    code = (trip_code_in > lsic_pkg::CODE_MAX) ? lsic_pkg::CODE_MAX :
           trip_code_in;                                       // RULE13
    if (motor_swap_cfg_in)                                     // RULE17
      unique case (trip_code_in)
        lsic_pkg::CODE_LEFT_OPEN:   code = lsic_pkg::CODE_RIGHT_OPEN;
        lsic_pkg::CODE_LEFT_SHORT:  code = lsic_pkg::CODE_RIGHT_SHORT;
        lsic_pkg::CODE_RIGHT_OPEN:  code = lsic_pkg::CODE_LEFT_OPEN;
        lsic_pkg::CODE_RIGHT_SHORT: code = lsic_pkg::CODE_LEFT_SHORT;
        default:                    code = code;
      endcase
  end

  // Codes 1..10 keep their meanings; the block only counts LEDs
  wire [9:0] code_bar = 10'((11'h001 << (comms_fault_in ?
                        lsic_pkg::CODE_COMMS : code)) - 11'h001); // RULE14 RULE15
  wire [9:0] batt_bar = (batt_level_in == lsic_pkg::BATT_FULL) ?
                        lsic_pkg::BAR_FULL :
                        (batt_level_in == lsic_pkg::BATT_SOON) ?
                        lsic_pkg::BAR_SOON : lsic_pkg::BAR_URGENT; // RULE23
  wire [9:0] chg_bar  = 10'((11'h002 << anim) - 11'h001);
  wire any_trip = trip_in | comms_fault_in;

  // Battery gauge priority: trip, charging, low, steady
  wire [9:0] next_batt =
    any_trip    ? (fast_ph ? code_bar : 10'h000) :             // RULE12 RULE24
    charging_in ? chg_bar :                                    // RULE11
    batt_low_in ? (slow_ph ? batt_bar : 10'h000) :             // RULE10
    batt_bar;

  // Ripple position: 0..4 then back 4..0 over a ten-step cycle
  wire [2:0] bounce = (anim < 4'h5) ? anim[2:0] : 3'(4'h9 - anim);
  wire [2:0] centre = (anim[1:0] == 2'h3) ? 3'h2 : {1'b0, anim[1:0]};
  wire [4:0] ripple_out = 5'h04 | (5'h04 << centre) | (5'h04 >> centre);
  wire [4:0] bar_speed  = 5'((6'h01 << level) - 6'h01);         // RULE20
  wire [4:0] one_prof   = 5'(6'h01 << (level - 3'h1));           // RULE21
  wire drive_like = (mode == lsic_pkg::LSIC_MODE_DRIVE) | in_act;

  wire [4:0] next_speed =
    comms_fault_in ? (fast_ph ? 5'h1F : 5'h00) :                // RULE16
    trip_in        ? 5'h00 :                                    // RULE24
    locked_in      ? 5'(6'h01 << bounce) :                      // RULE22
    reconfig_in    ? ripple_out :                               // RULE18
    reboot_req_in  ? (slow_ph ? lsic_pkg::REBOOT_MASK : 5'h00) : // RULE19
    !drive_like    ? 5'h00 :                                    // RULE7
    profile_cfg_in ? one_prof : bar_speed;

  wire [4:0] next_act_led =
    act_trip_in ? (fast_ph ? 5'h1F : 5'h00) :                   // RULE16
    in_act      ? 5'(6'h01 << act_sel) :                        // RULE8
    5'h00;                                                      // RULE7

  wire stop_all  = any_trip | chg_seen;
  wire next_up   = in_act & joy_fwd_in & ~joy_back_in & ~stop_all;
  wire next_down = in_act & joy_back_in & ~joy_fwd_in & ~stop_all;

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      batt_led_out      <= 10'h000;
      speed_led_out     <= 5'h00;
      act_led_out       <= 5'h00;
      mode_out          <= 2'h0;
      level_out         <= lsic_pkg::LEVEL_RESET;
      act_sel_out       <= lsic_pkg::ACT_RESET;
      act_up_out        <= 1'b0;
      act_down_out      <= 1'b0;
      drive_inhibit_out <= 1'b0;
    end
    else
    begin
      batt_led_out      <= next_batt;
      speed_led_out     <= next_speed;
      act_led_out       <= next_act_led;
      mode_out          <= mode;
      level_out         <= level;
      act_sel_out       <= act_sel;
      act_up_out        <= next_up;                             // RULE9
      act_down_out      <= next_down;                           // RULE9
      drive_inhibit_out <= stop_all;                            // RULE11 RULE12
    end
  end

  chk_trip_inhibit: assert property (                           // RULE12
    @(posedge core_clk_in) disable iff (!rstn_in)
    trip_in |=> drive_inhibit_out)
    else $error("trip did not inhibit drive");
  chk_mode_blank: assert property (                             // RULE7
    @(posedge core_clk_in) disable iff (!rstn_in)
    mode == lsic_pkg::LSIC_MODE_OTHER && !act_trip_in && !locked_in
    && !reconfig_in && !reboot_req_in && !comms_fault_in
    |=> speed_led_out == 5'h00 && act_led_out == 5'h00)
    else $error("leds lit outside drive or seating");
  chk_dec_level: assert property (                              // RULE3
    @(posedge core_clk_in) disable iff (!rstn_in)
    do_dec |=> level == $past(level) - 3'h1)
    else $error("decrease press not applied");
  chk_inc_level: assert property (                              // RULE4
    @(posedge core_clk_in) disable iff (!rstn_in)
    do_inc |=> level == $past(level) + 3'h1)
    else $error("increase press not applied");
  chk_btn_lockout: assert property (                            // RULE5
    @(posedge core_clk_in) disable iff (!rstn_in)
    lock_out_btn_cfg_in && driving_in && level <= top |=> $stable(level))
    else $error("buttons acted while driving");
  chk_level_range: assert property (                            // RULE1
    @(posedge core_clk_in) disable iff (!rstn_in)
    level >= 3'h1 && level <= 3'h5)
    else $error("level out of range");
  chk_speed_bar: assert property (                              // RULE20
    @(posedge core_clk_in) disable iff (!rstn_in)
    mode == lsic_pkg::LSIC_MODE_DRIVE && !profile_cfg_in && !trip_in
    && !comms_fault_in && !locked_in && !reconfig_in && !reboot_req_in
    |=> $countones(speed_led_out) == $past(level))
    else $error("speed bar length wrong");
  chk_trip_count: assert property (                             // RULE13
    @(posedge core_clk_in) disable iff (!rstn_in)
    trip_in && !comms_fault_in && fast_ph && !motor_swap_cfg_in
    && trip_code_in <= 4'hA
    |=> $countones(batt_led_out) == $past(trip_code_in))
    else $error("trip count mismatch");
  chk_charge_latch: assert property (                           // RULE11
    @(posedge core_clk_in) disable iff (!rstn_in)
    charging_in |=> ##1 drive_inhibit_out [*3])
    else $error("charge inhibit not held");
  chk_profile_one: assert property (                            // RULE21
    @(posedge core_clk_in) disable iff (!rstn_in)
    mode == lsic_pkg::LSIC_MODE_DRIVE && profile_cfg_in && !trip_in
    && !comms_fault_in && !locked_in && !reconfig_in && !reboot_req_in
    |=> $onehot(speed_led_out))
    else $error("profile gauge not one-hot");
  chk_reboot_mask: assert property (                            // RULE19
    @(posedge core_clk_in) disable iff (!rstn_in)
    reboot_req_in && !trip_in && !comms_fault_in && !locked_in
    && !reconfig_in
    |=> (speed_led_out & ~lsic_pkg::REBOOT_MASK) == 5'h00)
    else $error("reboot flash lit wrong leds");
  chk_trip_motion: assert property (                            // RULE12
    @(posedge core_clk_in) disable iff (!rstn_in)
    trip_in |=> !act_up_out && !act_down_out)
    else $error("actuator moved during trip");
  chk_swap_code: assert property (                              // RULE17
    @(posedge core_clk_in) disable iff (!rstn_in)
    trip_in && !comms_fault_in && fast_ph && motor_swap_cfg_in
    && trip_code_in == lsic_pkg::CODE_LEFT_OPEN
    |=> $countones(batt_led_out) == lsic_pkg::CODE_RIGHT_OPEN)
    else $error("motor swap not applied");
  chk_batt_steady: assert property (                            // RULE23
    @(posedge core_clk_in) disable iff (!rstn_in)
    !trip_in && !comms_fault_in && !charging_in && !batt_low_in
    && batt_level_in == lsic_pkg::BATT_FULL
    |=> batt_led_out == lsic_pkg::BAR_FULL)
    else $error("full gauge not steady");
  chk_charge_step: assert property (                            // RULE11
    @(posedge core_clk_in) disable iff (!rstn_in)
    charging_in && !trip_in && !comms_fault_in |=> batt_led_out[0])
    else $error("charge gauge dark at bottom");
  chk_act_onehot: assert property (                             // RULE8
    @(posedge core_clk_in) disable iff (!rstn_in)
    in_act && !act_trip_in |=> $onehot(act_led_out))
    else $error("actuator channel not shown");
  chk_comms_speed: assert property (                            // RULE16
    @(posedge core_clk_in) disable iff (!rstn_in)
    comms_fault_in && fast_ph |=> speed_led_out == 5'h1F)
    else $error("comms fault speed flash missing");
  cov_trip: cover property (@(posedge core_clk_in) trip_in && fast_ph);
  cov_comms: cover property (
    @(posedge core_clk_in) comms_fault_in && fast_ph);
  cov_reconfig: cover property (
    @(posedge core_clk_in) reconfig_in && step_en);
  cov_act: cover property (@(posedge core_clk_in) in_act && act_up_out);
  cov_lock: cover property (@(posedge core_clk_in) locked_in && step_en);
endmodule

// File: verif/lsic_user_model.sv
// Behavioural model of the user controls and the system status sources
`timescale 1ns/1ps
module lsic_user_model (
  input  wire logic       core_clk_in,
  output logic      [2:0] btn_out,
  output logic      [3:0] joy_out,
  output logic      [8:0] stat_out,
  output logic      [3:0] code_out,
  output logic      [1:0] batt_out
);
  initial
  begin
    btn_out  = 3'h0;
    joy_out  = 4'h0;
    stat_out = 9'h000;
    code_out = 4'h0;
    batt_out = 2'h0;
  end

  // Held two cycles, released two: design needs a release between presses
  task automatic press(input bit joy, input int b);
    @(negedge core_clk_in);
    if (joy)
      joy_out[b] = 1'b1;
    else
      btn_out[b] = 1'b1;
    repeat (2) @(negedge core_clk_in);
    joy_out = 4'h0;
    btn_out = 3'h0;
    repeat (2) @(negedge core_clk_in);
  endtask

  // Level held until changed again, for forward and back drive
  task automatic hold(input int b, input bit v);
    @(negedge core_clk_in);
    joy_out[b] = v;
  endtask

  // Status word: driving, charging, trip, comms, act trip, reconfig,
  // reboot, locked, battery low
  task automatic status(input logic [8:0] s, input logic [3:0] c,
                        input logic [1:0] l);
    @(negedge core_clk_in);
    stat_out = s;
    code_out = c;
    batt_out = l;
  endtask
endmodule

// File: verif/testbench.sv
// Self-checking testbench for the LED status indicator control block
`timescale 1ns/1ps
module testbench;
  logic       core_clk_in = 1'b0;
  logic       rstn_in = 1'b0;
  logic       prof_cfg = 1'b0;
  logic       lockout = 1'b0;
  logic       swap = 1'b0;
  logic [2:0] pcount = 3'h3;
  logic [3:0] avail = 4'hF;
  logic [2:0] btn;
  logic [3:0] joy;
  logic [8:0] stat;
  logic [3:0] code;
  logic [1:0] batt;
  logic [9:0] batt_led;
  logic [4:0] speed_led;
  logic [4:0] act_led;
  logic [1:0] mode;
  logic [2:0] level;
  logic [2:0] act_sel;
  logic       act_up;
  logic       act_down;
  logic       inhibit;
  int         err_total = 0;
  int         cmp_count = 0;

  always #10 core_clk_in = ~core_clk_in;

  lsic_user_model PM (.core_clk_in(core_clk_in), .btn_out(btn),
    .joy_out(joy), .stat_out(stat), .code_out(code), .batt_out(batt));

  // Short flash and step counts keep the run brief
  lsic_led_status #(.SLOW_CYCLES(4), .FAST_CYCLES(2), .STEP_CYCLES(3)) DUT (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .dec_btn_in(btn[0]),
    .inc_btn_in(btn[1]), .mode_btn_in(btn[2]), .joy_left_in(joy[0]),
    .joy_right_in(joy[1]), .joy_fwd_in(joy[2]), .joy_back_in(joy[3]),
    .driving_in(stat[0]), .profile_cfg_in(prof_cfg),
    .profile_count_in(pcount), .lock_out_btn_cfg_in(lockout),
    .mode_avail_in(avail), .motor_swap_cfg_in(swap),
    .batt_level_in(batt), .batt_low_in(stat[8]), .charging_in(stat[1]),
    .trip_in(stat[2]), .trip_code_in(code), .comms_fault_in(stat[3]),
    .act_trip_in(stat[4]), .reconfig_in(stat[5]), .reboot_req_in(stat[6]),
    .locked_in(stat[7]), .batt_led_out(batt_led), .speed_led_out(speed_led),
    .act_led_out(act_led), .mode_out(mode), .level_out(level),
    .act_sel_out(act_sel), .act_up_out(act_up), .act_down_out(act_down),
    .drive_inhibit_out(inhibit));

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle;
    repeat (5) @(negedge core_clk_in);
  endtask

  // Strict: only blank or the mask may show. Loose: pattern must move.
  task automatic watch(input int sel, input logic [9:0] m, input bit strict);
    logic [9:0] v;
    logic [9:0] last;
    int         moves;
    bit         seen;
    seen = (m === 10'h000);
    moves = 0;
    last = 10'h000;
    repeat (30)
    begin
      @(negedge core_clk_in);
      v = sel == 0 ? batt_led : sel == 1 ? {5'h00, speed_led}
                                         : {5'h00, act_led};
      if (v === m)
        seen = 1'b1;
      else if (strict && v !== 10'h000)
        chk(v, m);
      if (v !== last)
        moves++;
      last = v;
    end
    chk({9'h000, seen}, 10'h001);
    if (!strict)
      chk({9'h000, moves >= 2}, 10'h001);
  endtask

  task automatic results;
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(negedge core_clk_in);
    chk({7'h00, level}, 10'h001);
    chk(batt_led | {speed_led, act_led}, 10'h000);
    rstn_in = 1'b1;
    settle;
    for (int l = 0; l < 3; l++)
    begin
      PM.status(9'h000, 4'h0, 2'(l));
      settle;
      chk(batt_led, l == 0 ? 10'h3FF : l == 1 ? 10'h07F : 10'h007);
    end
    PM.status(9'h000, 4'h0, 2'h0);
    for (int i = 2; i <= 6; i++)
    begin
      PM.press(0, 1);
      settle;
      chk({7'h00, level}, 10'(i > 5 ? 5 : i));
      chk({5'h00, speed_led}, i > 5 ? 10'h01F : 10'((1 << i) - 1));
    end
    for (int i = 4; i >= 0; i--)
    begin
      PM.press(0, 0);
      settle;
      chk({7'h00, level}, 10'(i < 1 ? 1 : i));
    end
    lockout = 1'b1;
    PM.status(9'h001, 4'h0, 2'h0);
    PM.press(0, 1);
    settle;
    chk({7'h00, level}, 10'h001);
    PM.status(9'h000, 4'h0, 2'h0);
    PM.press(0, 1);
    settle;
    chk({7'h00, level}, 10'h002);
    prof_cfg = 1'b1;
    settle;
    chk({5'h00, speed_led}, 10'h002);
    PM.press(0, 1);
    PM.press(0, 1);
    settle;
    chk({5'h00, speed_led}, 10'h004);
    prof_cfg = 1'b0;
    PM.press(0, 2);
    settle;
    chk({8'h00, mode}, 10'h001);
    chk({5'h00, act_led}, 10'h001);
    PM.press(1, 1);
    settle;
    chk({5'h00, act_led}, 10'h002);
    PM.press(1, 0);
    settle;
    chk({7'h00, act_sel}, 10'h000);
    PM.hold(2, 1'b1);
    settle;
    chk({9'h000, act_up}, 10'h001);
    PM.hold(2, 1'b0);
    PM.hold(3, 1'b1);
    settle;
    chk({9'h000, act_down}, 10'h001);
    PM.hold(3, 1'b0);
    PM.press(0, 2);
    settle;
    chk({speed_led, act_led}, 10'h000);
    PM.press(0, 2);
    PM.press(0, 2);
    avail = 4'h5;
    PM.press(0, 2);
    settle;
    chk({8'h00, mode}, 10'h002);
    PM.press(0, 2);
    avail = 4'hF;
    PM.status(9'h100, 4'h0, 2'h0);
    settle;
    watch(0, 10'h3FF, 1);
    PM.status(9'h020, 4'h0, 2'h0);
    settle;
    watch(1, 10'h004, 0);
    PM.status(9'h040, 4'h0, 2'h0);
    settle;
    watch(1, 10'h00A, 1);
    PM.status(9'h080, 4'h0, 2'h0);
    settle;
    watch(1, 10'h010, 0);
    for (int c = 1; c <= 12; c++)
    begin
      swap = (c > 10);
      PM.status(9'h084, c > 10 ? 4'(c - 9) : 4'(c), 2'h0);
      settle;
      chk({9'h000, inhibit}, 10'h001);
      chk({5'h00, speed_led}, 10'h000);
      watch(0, 10'((1 << (c > 10 ? c - 7 : c)) - 1), 1);
    end
    swap = 1'b0;
    PM.status(9'h008, 4'h0, 2'h0);
    settle;
    watch(0, 10'h07F, 1);
    watch(1, 10'h01F, 1);
    PM.status(9'h010, 4'h0, 2'h0);
    settle;
    watch(2, 10'h01F, 1);
    PM.status(9'h002, 4'h0, 2'h0);
    settle;
    watch(0, 10'h3FF, 0);
    PM.status(9'h006, 4'h3, 2'h0);
    settle;
    watch(0, 10'h007, 1);
    PM.status(9'h000, 4'h0, 2'h0);
    settle;
    chk({9'h000, inhibit}, 10'h001);
    rstn_in = 1'b0;
    settle;
    rstn_in = 1'b1;
    settle;
    chk({9'h000, inhibit}, 10'h000);
    results;
  end
endmodule
